// ---- dv/nfh_dev_model.sv ----
/*
  Behavioural model of the flash device that stands on the far side of the host sequencer.
  Assumes the bench resolves the io pins and pulls the ready/busy wire up.
*/
`timescale 1ns/1ns
module nfh_dev_model #(
	parameter int INIT_CYC = 5000, // Power-on busy time in clocks.
	parameter int OP_CYC   = 300   // Array busy time in clocks.
) (
	input  wire logic        clk,     // System clock.
	input  wire logic        rst_n,   // Power-on, active low.
	input  wire logic        cle,     // Command latch enable.
	input  wire logic        ale,     // Address latch enable.
	input  wire logic        ce_n,    // Chip enable, active low.
	input  wire logic        we_n,    // Write enable, active low.
	input  wire logic        re_n,    // Read enable, active low.
	input  wire logic        wp_n,    // Write protect, active low.
	input  wire logic [7:0]  din,     // Byte from the host.
	input  wire logic [11:0] bad_blk, // Block carrying the bad mark.
	input  wire logic        fail_pg, // Next program fails.
	output logic      [7:0]  dout,    // Byte to the host.
	output logic             rb_low,  // Pulls the ready/busy wire low.
	output logic      [7:0]  n_viol,  // Host usage faults seen.
	output logic      [7:0]  n_reset  // Reset commands seen.
);
	logic [7:0] mem [int];
	logic [7:0] pend [int];
	int         lastpg [int];
	int         nprog [int];
	logic [7:0] a [0:5];
	int         na = 0, key = 0, rkey = 0, cyc = 0, bend = INIT_CYC;
	logic       inprog = 1'b0, smode = 1'b0, fail_q = 1'b0;
	initial n_viol = 8'h00;
	initial n_reset = 8'h00;
	initial dout = 8'hFF;

	function automatic logic [17:0] rowk(input int b);
		return {a[b + 2][1:0], a[b + 1], a[b]};
	endfunction

	// Time base; the wire stays low until the busy end time is reached.
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
			cyc <= 0;
		else
			cyc <= cyc + 1;
	assign rb_low = (cyc < bend);

	// Command decoder; it also counts every command the host was not allowed to send.
	task automatic cmd(input logic [7:0] c);
		int b;
		if (cyc < INIT_CYC && !(c inside {8'hFF, 8'h70})) n_viol++;
		if (!(c inside {8'h00, 8'h30, 8'h80, 8'h10, 8'h85, 8'h11, 8'h15, 8'h60, 8'hD0,
			8'h70, 8'h71, 8'hFF})) n_viol++;
		if (rb_low && !(c inside {8'h70, 8'h71, 8'hFF})) n_viol++;
		if (inprog && !(c inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hFF})) n_viol++;
		if (c != 8'h85 && c != 8'h10) pend.delete();
		case (c)
			8'h00: begin na = 0; smode = 1'b0; end
			8'h30: begin rkey = key; bend = cyc + OP_CYC; end
			8'h80: begin na = 0; inprog = 1'b1; end
			8'h60: na = 0;
			8'h10:
			begin
				b = key >> 13;
				if (lastpg.exists(b >> 6) && (b & 63) < lastpg[b >> 6]) n_viol++;
				nprog[b] = nprog.exists(b) ? nprog[b] + 1 : 1;
				if (nprog[b] > 4) n_viol++;
				lastpg[b >> 6] = b & 63;
				fail_q = fail_pg || !wp_n;
				if (!fail_q) foreach (pend[k]) mem[k] = pend[k];
				pend.delete();
				inprog = 1'b0;
				bend = cyc + OP_CYC;
			end
			8'hD0:
			begin
				b = rowk(0) >> 6;
				if (b == bad_blk) n_viol++;
				fail_q = !wp_n;
				lastpg.delete(b);
				for (int p = 0; p < 64; p++) nprog.delete(b * 64 + p);
				bend = cyc + OP_CYC;
			end
			8'h70, 8'h71: smode = 1'b1;
			8'hFF:
			begin
				inprog = 1'b0;
				n_reset++;
				bend = (cyc < INIT_CYC) ? INIT_CYC : cyc + 20;
			end
			default: ;
		endcase
	endtask

	// Bytes are taken on the rising edge of write enable.
	always @(posedge we_n)
		if (!ce_n)
		begin
			if (cle)
				cmd(din);
			else if (ale)
			begin
				if (na < 6) a[na] = din;
				na++;
				key = {rowk(2), a[1][4:0], a[0]};
			end
			else if (inprog)
			begin
				pend[key] = din;
				key++;
			end
		end

	// A released bus shows the inverse of the last byte, so a late sample cannot pass.
	always @(re_n)
		if (re_n)
			dout = ~dout;
		else if (!ce_n)
		begin
			if (smode)
				dout = {wp_n, ~rb_low, ~rb_low, 4'h0, fail_q};
			// A single marked block leaves the good block count far above its floor.
			else if ((rkey >> 19) == bad_blk)
				dout = 8'h00;
			else
				dout = mem.exists(rkey) ? mem[rkey] : 8'hFF;
			if (!smode) rkey++;
		end

	// Dropping write protect cuts a running array operation short.
	always @(negedge wp_n)
		if (rb_low && cyc >= INIT_CYC)
			bend = cyc;
endmodule

// ---- dv/testbench.sv ----
/*
  Self-checking bench for the flash host sequencer against the behavioural device model.
  Assumes the package, the design and the model are compiled before it.
*/
`timescale 1ns/1ns
module testbench;
	logic        clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, ecc_fail = 1'b0, fail_pg = 1'b0;
	logic [2:0]  req_op = 3'h0;
	logic [11:0] req_blk = 12'h000;
	logic [5:0]  req_pg = 6'h00;
	logic [12:0] req_col = 13'h0010, req_len = 13'h0000;
	logic [7:0]  wr_data = 8'h00;
	logic        wr_take, rd_valid, busy, done, done_err, refused, io_oe, cle, ale;
	logic        ce_n, we_n, re_n, wp_n, rb_low, ready_busy_n_output, f_done, f_ref, f_err;
	logic [7:0]  rd_data, io_out, io_in, dout, n_viol, n_reset;
	logic [7:0]  got [$];
	int          n_take, n_fail = 0, samples_checked = 0;

	// Clock, resolved io bus and the pulled-up ready wire.
	always #5 clk = ~clk;
	assign io_in = io_oe ? io_out : dout;
	assign ready_busy_n_output = rb_low ? 1'b0 : 1'b1;

	nfh_host dut_u (.clk, .rst_n, .req_valid, .req_op, .req_blk, .req_pg, .req_col, .req_len,
		.wr_data, .ecc_fail, .wr_take, .rd_data, .rd_valid, .busy, .done, .done_err, .refused,
		.io_in, .io_out, .io_oe, .cle, .ale, .ce_n, .we_n, .re_n, .wp_n, .ready_busy_n_output);
	nfh_dev_model dev_u (.clk, .rst_n, .cle, .ale, .ce_n, .we_n, .re_n, .wp_n, .din(io_out),
		.bad_blk(12'h009), .fail_pg, .dout, .rb_low, .n_viol, .n_reset);

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One request pulse, then a bounded watch for its end, logging bytes both ways.
	task automatic run_op(input logic [2:0] op, input logic [11:0] blk, input logic [5:0] pg,
		input logic [12:0] len, input logic [7:0] base);
		int k;
		got.delete();
		n_take = 0;
		f_done = 1'b0;
		f_ref = 1'b0;
		@(negedge clk);
		{req_op, req_blk, req_pg, req_len, wr_data, req_valid} = {op, blk, pg, len, base, 1'b1};
		@(negedge clk);
		req_valid = 1'b0;
		for (k = 0; k < 8000 && !f_done && !f_ref; k++)
		begin
			if (refused === 1'b1) f_ref = 1'b1;
			if (done === 1'b1) {f_done, f_err} = {1'b1, done_err};
			if (rd_valid === 1'b1) got.push_back(rd_data);
			if (wr_take === 1'b1) n_take++;
			wr_data = base + 8'(n_take);
			if (!f_done && !f_ref) @(negedge clk);
		end
		if (!f_done && !f_ref)
		begin
			n_fail++;
			give_verdict();
		end
	endtask

	task automatic outcome(input logic r, input logic e);
		check("refused", f_ref, r);
		if (!r) check("done_err", f_err, e);
	endtask

	// Power-on: busy through the sweep and the device's own start-up, one reset sent.
	task automatic t_init();
		int k;
		@(negedge clk);
		check("busy_init", busy, 1'b1);
		for (k = 0; k < 7000 && busy !== 1'b0; k++) @(negedge clk);
		check("init_wait", logic'(k > 4900 && k < 7000), 1'b1);
		check("init_resets", n_reset, 8'h01);
		check("wp_idle", wp_n, 1'b0);
	endtask

	// Program four bytes and read them back from the same place.
	task automatic t_prog_read();
		run_op(nfh_pkg::OP_PROG, 12'h005, 6'h02, 13'h0003, 8'hA0);
		outcome(1'b0, 1'b0);
		check("takes", 16'(n_take), 16'h0004);
		run_op(nfh_pkg::OP_READ, 12'h005, 6'h02, 13'h0003, 8'h00);
		check("rd_count", 16'(got.size()), 16'h0004);
		foreach (got[i]) check("rd_byte", got[i], 8'hA0 + 8'(i));
	endtask

	// A lower page is refused; a page takes four programs and no fifth.
	task automatic t_order();
		int k;
		run_op(nfh_pkg::OP_PROG, 12'h005, 6'h01, 13'h0000, 8'h11);
		outcome(1'b1, 1'b0);
		for (k = 0; k < 4; k++)
		begin
			run_op(nfh_pkg::OP_PROG, 12'h005, 6'h02, 13'h0000, 8'hFF);
			outcome(logic'(k == 3), 1'b0);
		end
	endtask

	// A failed program retires its block for reads, programs and erases.
	task automatic t_fail();
		fail_pg = 1'b1;
		run_op(nfh_pkg::OP_PROG, 12'h007, 6'h00, 13'h0000, 8'h5A);
		fail_pg = 1'b0;
		outcome(1'b0, 1'b1);
		run_op(nfh_pkg::OP_READ, 12'h007, 6'h00, 13'h0000, 8'h00);
		outcome(1'b1, 1'b0);
		run_op(nfh_pkg::OP_PROG, 12'h007, 6'h01, 13'h0000, 8'h00);
		outcome(1'b1, 1'b0);
		run_op(nfh_pkg::OP_ERASE, 12'h007, 6'h00, 13'h0000, 8'h00);
		outcome(1'b1, 1'b0);
	endtask

	// Scan a marked block and a clean one; the marked block may not be erased.
	task automatic t_scan();
		run_op(nfh_pkg::OP_SCAN, 12'h009, 6'h00, 13'h0000, 8'h00);
		outcome(1'b0, 1'b1);
		check("scan_byte", got[0], 8'h00);
		run_op(nfh_pkg::OP_ERASE, 12'h009, 6'h00, 13'h0000, 8'h00);
		outcome(1'b1, 1'b0);
		run_op(nfh_pkg::OP_SCAN, 12'h003, 6'h00, 13'h0000, 8'h00);
		outcome(1'b0, 1'b0);
	endtask

	// Unknown codes, a read with a failed correction, a reset, then erase and restart.
	task automatic t_misc();
		int k;
		for (k = 5; k < 8; k++)
		begin
			run_op(3'(k), 12'h003, 6'h00, 13'h0000, 8'h00);
			outcome(1'b1, 1'b0);
		end
		ecc_fail = 1'b1;
		run_op(nfh_pkg::OP_READ, 12'h005, 6'h02, 13'h0001, 8'h00);
		ecc_fail = 1'b0;
		outcome(1'b0, 1'b1);
		run_op(nfh_pkg::OP_RESET, 12'h000, 6'h00, 13'h0000, 8'h00);
		outcome(1'b0, 1'b0);
		check("resets", n_reset, 8'h02);
		run_op(nfh_pkg::OP_ERASE, 12'h005, 6'h00, 13'h0000, 8'h00);
		outcome(1'b0, 1'b0);
		run_op(nfh_pkg::OP_PROG, 12'h005, 6'h00, 13'h0000, 8'h33);
		outcome(1'b0, 1'b0);
		check("host_faults", n_viol, 8'h00);
	endtask

	// Main sequence; reset is released on a falling edge after six cycles.
	initial
	begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_init();
		t_prog_read();
		t_order();
		t_fail();
		t_scan();
		t_misc();
		give_verdict();
	end
endmodule

// ---- src/nfh_host.sv ----
/*
  Host sequencer that drives one NAND flash device over its byte-wide pins, polls the
  ready/busy line and status, and keeps bad block and page order tables.
  Assumes an external pull-up on the ready/busy wire and a bench that resolves io pins.
*/
`timescale 1ns/1ns
module nfh_host (
	input  wire logic                      clk,         // System clock.
	input  wire logic                      rst_n,       // Asynchronous reset, active low.
	input  wire logic                      req_valid,   // Operation request pulse.
	input  wire logic [2:0]                req_op,      // Operation code.
	input  wire logic [nfh_pkg::BLK_W-1:0] req_blk,     // Block number.
	input  wire logic [nfh_pkg::PG_W-1:0]  req_pg,      // Page within block.
	input  wire logic [nfh_pkg::COL_W-1:0] req_col,     // Starting column.
	input  wire logic [nfh_pkg::COL_W-1:0] req_len,     // Byte count minus one.
	input  wire logic [7:0]                wr_data,     // Program data byte.
	input  wire logic                      ecc_fail,    // Uncorrectable result from ECC.
	output logic                           wr_take,     // Program byte consumed.
	output logic [7:0]                     rd_data,     // Read data byte.
	output logic                           rd_valid,    // Read data strobe.
	output logic                           busy,        // Operation in progress.
	output logic                           done,        // Operation finished pulse.
	output logic                           done_err,    // Failure with done.
	output logic                           refused,     // Request refused pulse.
	input  wire logic [7:0]                io_in,       // Device io pins, sensed.
	output logic [7:0]                     io_out,      // Device io pins, driven.
	output logic                           io_oe,       // High while driving io.
	output logic                           cle,         // Command latch enable.
	output logic                           ale,         // Address latch enable.
	output logic                           ce_n,        // Chip enable, active low.
	output logic                           we_n,        // Write enable, active low.
	output logic                           re_n,        // Read enable, active low.
	output logic                           wp_n,        // Write protect, active low.
	input  wire logic                      ready_busy_n_output // Wired ready/busy line.
);
	nfh_pkg::nfh_state_type state_q;
	logic [7:0]                io_s1_q, io_s2_q;
	logic                      rb_s1_q, rb_s2_q;
	logic [7:0]                cnt_q;
	logic [nfh_pkg::COL_W-1:0] idx_q, col_q, len_q;
	logic [nfh_pkg::BLK_W-1:0] blk_q;
	logic [nfh_pkg::PG_W-1:0]  pg_q;
	logic [2:0]                op_q;
	logic [7:0]                c1_q, c2_q, last_cmd_q;
	logic                      init_q, ev_bad_q, ev_prog_q, ev_erase_q;
	logic [nfh_pkg::BLK_W:0]   clr_q;
	logic                      bad_q  [nfh_pkg::BLOCKS];
	logic [nfh_pkg::PG_W-1:0]  lastp_q [nfh_pkg::BLOCKS];
	logic [2:0]                pcnt_q [nfh_pkg::BLOCKS];
	logic                      wr_st, rd_st, lo, last, smp, refuse, order_bad, op_ok;
	logic [7:0]                io_byte, abyte;

	// Pins from outside the clock domain pass two flip-flops before use.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			io_s1_q <= 8'h00;
			io_s2_q <= 8'h00;
			rb_s1_q <= 1'b0;
			rb_s2_q <= 1'b0;
		end
		else
		begin
			io_s1_q <= io_in;
			io_s2_q <= io_s1_q;
			rb_s1_q <= ready_busy_n_output;
			rb_s2_q <= rb_s1_q;
		end
	end

	// Byte cycle timing: the strobe opens one cycle after the data is set up.
	always_comb
	begin
		wr_st = state_q inside {nfh_pkg::S_CMD1, nfh_pkg::S_ADDR, nfh_pkg::S_WDATA,
			nfh_pkg::S_CMD2, nfh_pkg::S_SCMD};
		rd_st = state_q inside {nfh_pkg::S_SRD, nfh_pkg::S_RDATA};
		lo    = (cnt_q >= 8'h01) && (cnt_q <= (wr_st ? 8'(nfh_pkg::WE_LOW_CYC)
			: 8'(nfh_pkg::RE_LOW_CYC)));
		last  = cnt_q == (wr_st ? 8'(nfh_pkg::WE_CYC - 1) : 8'(nfh_pkg::RE_CYC - 1));
		smp   = rd_st && (cnt_q == 8'(nfh_pkg::RE_LOW_CYC + 1));
		unique case (idx_q[2:0])
			3'h0: abyte = col_q[7:0];
			3'h1: abyte = {3'h0, col_q[12:8]};
			3'h2: abyte = {blk_q[1:0], pg_q};
			3'h3: abyte = blk_q[9:2];
			default: abyte = {6'h00, blk_q[11:10]};
		endcase
		unique case (state_q)
			nfh_pkg::S_CMD1:  io_byte = c1_q;
			nfh_pkg::S_ADDR:  io_byte = abyte;
			nfh_pkg::S_WDATA: io_byte = wr_data;
			nfh_pkg::S_CMD2:  io_byte = c2_q;
			nfh_pkg::S_SCMD:  io_byte = nfh_pkg::CMD_STATUS;
			default: io_byte = 8'h00;
		endcase
	end

	// Request screening against the tables.
	always_comb
	begin
		op_ok     = req_op inside {nfh_pkg::OP_READ, nfh_pkg::OP_PROG, nfh_pkg::OP_ERASE,
			nfh_pkg::OP_RESET, nfh_pkg::OP_SCAN};
		order_bad = (req_op == nfh_pkg::OP_PROG) && (pcnt_q[req_blk] != 3'h0) &&
			((req_pg < lastp_q[req_blk]) ||
			((req_pg == lastp_q[req_blk]) && (pcnt_q[req_blk] >= nfh_pkg::MAX_PARTIAL)));
		// A failed or bad block is closed to everything but a scan or a reset.
		refuse    = !op_ok || order_bad || (bad_q[req_blk] &&
			!(req_op inside {nfh_pkg::OP_RESET, nfh_pkg::OP_SCAN}));
	end

	// Main sequencer; pins are registered so every output comes from a flip-flop.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= nfh_pkg::S_INIT;
			cnt_q <= 8'h00;
			idx_q <= '0;
			col_q <= '0;
			len_q <= '0;
			blk_q <= '0;
			pg_q <= '0;
			op_q <= nfh_pkg::OP_RESET;
			c1_q <= nfh_pkg::CMD_RESET;
			c2_q <= nfh_pkg::CMD_RESET;
			init_q <= 1'b1;
			{wr_take, rd_valid, done, done_err, refused, busy} <= 6'h01;
			{ev_bad_q, ev_prog_q, ev_erase_q} <= 3'h0;
			rd_data <= 8'h00;
			io_out <= 8'h00;
			{io_oe, cle, ale, ce_n, we_n, re_n, wp_n} <= 7'h1C;
		end
		else
		begin
			{wr_take, rd_valid, done, refused, ev_bad_q, ev_prog_q, ev_erase_q} <= 7'h00;
			io_out <= io_byte;
			io_oe <= wr_st;
			cle <= state_q inside {nfh_pkg::S_CMD1, nfh_pkg::S_CMD2, nfh_pkg::S_SCMD};
			ale <= state_q == nfh_pkg::S_ADDR;
			we_n <= !(wr_st && lo);
			re_n <= !(rd_st && lo);
			ce_n <= state_q == nfh_pkg::S_IDLE;
			// Protect is lifted only for a program or erase in flight.
			wp_n <= busy && (op_q inside {nfh_pkg::OP_PROG, nfh_pkg::OP_ERASE});
			cnt_q <= (last || !(wr_st || rd_st)) ? 8'h00 : cnt_q + 8'h01;
			if (state_q == nfh_pkg::S_TWB)
				cnt_q <= cnt_q + 8'h01;
			unique case (state_q)
				nfh_pkg::S_INIT:
					if (clr_q[nfh_pkg::BLK_W])
						state_q <= nfh_pkg::S_CMD1;
				nfh_pkg::S_IDLE:
					if (req_valid && refuse)
						refused <= 1'b1;
					else if (req_valid)
					begin
						busy <= 1'b1;
						done_err <= 1'b0;
						op_q <= req_op;
						blk_q <= req_blk;
						pg_q <= (req_op == nfh_pkg::OP_SCAN) ? '0 : req_pg;
						col_q <= req_col;
						len_q <= (req_op == nfh_pkg::OP_SCAN) ? '0 : req_len;
						state_q <= nfh_pkg::S_CMD1;
						unique case (req_op)
							nfh_pkg::OP_PROG:
							begin
								c1_q <= nfh_pkg::CMD_PROG1;
								c2_q <= nfh_pkg::CMD_PROG2;
							end
							nfh_pkg::OP_ERASE:
							begin
								c1_q <= nfh_pkg::CMD_ERASE1;
								c2_q <= nfh_pkg::CMD_ERASE2;
							end
							nfh_pkg::OP_RESET:
								c1_q <= nfh_pkg::CMD_RESET;
							default:
							begin
								c1_q <= nfh_pkg::CMD_READ1;
								c2_q <= nfh_pkg::CMD_READ2;
							end
						endcase
					end
				nfh_pkg::S_CMD1:
					if (last)
					begin
						idx_q <= {10'h000, (op_q == nfh_pkg::OP_ERASE) ?
							nfh_pkg::ADDR_FIRST_ROW : nfh_pkg::ADDR_FIRST_FULL};
						state_q <= (op_q == nfh_pkg::OP_RESET) ? nfh_pkg::S_TWB :
							nfh_pkg::S_ADDR;
					end
				nfh_pkg::S_ADDR:
					// Exactly five address cycles, three for erase; never a sixth.
					if (last && idx_q[2:0] == nfh_pkg::ADDR_LAST)
					begin
						idx_q <= '0;
						state_q <= (op_q == nfh_pkg::OP_PROG) ? nfh_pkg::S_WDATA :
							nfh_pkg::S_CMD2;
					end
					else if (last)
						idx_q <= idx_q + 1'b1;
				nfh_pkg::S_WDATA:
					if (last)
					begin
						wr_take <= 1'b1;
						idx_q <= idx_q + 1'b1;
						if (idx_q == len_q)
							state_q <= nfh_pkg::S_CMD2;
					end
				nfh_pkg::S_CMD2:
					if (last)
						state_q <= nfh_pkg::S_TWB;
				nfh_pkg::S_TWB:
					if (cnt_q == 8'(nfh_pkg::TWB_CYC - 1))
						state_q <= nfh_pkg::S_RB;
				nfh_pkg::S_RB:
					// No command leaves until the line reports ready.
					if (rb_s2_q)
					begin
						idx_q <= '0;
						if (op_q == nfh_pkg::OP_RESET)
						begin
							state_q <= nfh_pkg::S_IDLE;
							init_q <= 1'b0;
							busy <= 1'b0;
							done <= !init_q;
						end
						else
							state_q <= (op_q inside {nfh_pkg::OP_PROG, nfh_pkg::OP_ERASE}) ?
								nfh_pkg::S_SCMD : nfh_pkg::S_RDATA;
					end
				nfh_pkg::S_SCMD:
					if (last)
						state_q <= nfh_pkg::S_SRD;
				nfh_pkg::S_SRD:
				begin
					if (smp)
						rd_data <= io_s2_q;
					// The fail bit counts only once the ready bit is set.
					if (last && !rd_data[nfh_pkg::ST_READY_BIT])
						state_q <= nfh_pkg::S_SCMD;
					else if (last)
					begin
						state_q <= nfh_pkg::S_IDLE;
						busy <= 1'b0;
						done <= 1'b1;
						done_err <= rd_data[nfh_pkg::ST_FAIL_BIT];
						ev_bad_q <= rd_data[nfh_pkg::ST_FAIL_BIT];
						ev_prog_q <= !rd_data[nfh_pkg::ST_FAIL_BIT] && op_q == nfh_pkg::OP_PROG;
						ev_erase_q <= !rd_data[nfh_pkg::ST_FAIL_BIT] &&
							op_q == nfh_pkg::OP_ERASE;
					end
				end
				nfh_pkg::S_RDATA:
				begin
					if (smp)
					begin
						rd_data <= io_s2_q;
						rd_valid <= 1'b1;
						if (op_q == nfh_pkg::OP_SCAN && io_s2_q == nfh_pkg::BAD_MARK)
						begin
							ev_bad_q <= 1'b1;
							done_err <= 1'b1;
						end
					end
					if (last)
						idx_q <= idx_q + 1'b1;
					if (last && idx_q == len_q)
					begin
						state_q <= nfh_pkg::S_IDLE;
						busy <= 1'b0;
						done <= 1'b1;
						if (ecc_fail)
							done_err <= 1'b1;
					end
				end
				default:
					state_q <= nfh_pkg::S_IDLE;
			endcase
		end
	end

	// Tables start cleared by a sweep, since a reset on thousands of entries is too costly.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			clr_q <= '0;
		else if (!clr_q[nfh_pkg::BLK_W])
			clr_q <= clr_q + 1'b1;
	end

	// Bad block and page order tables, updated by failures, scanned bad marks, finished programs and erases.
	always_ff @(posedge clk)
	begin
		if (!clr_q[nfh_pkg::BLK_W])
		begin
			bad_q[clr_q[nfh_pkg::BLK_W-1:0]] <= 1'b0;
			pcnt_q[clr_q[nfh_pkg::BLK_W-1:0]] <= 3'h0;
			lastp_q[clr_q[nfh_pkg::BLK_W-1:0]] <= '0;
		end
		else if (ev_bad_q)
			bad_q[blk_q] <= 1'b1;
		else if (ev_erase_q)
			pcnt_q[blk_q] <= 3'h0;
		else if (ev_prog_q)
		begin
			lastp_q[blk_q] <= pg_q;
			pcnt_q[blk_q] <= (pcnt_q[blk_q] != 3'h0 && lastp_q[blk_q] == pg_q) ?
				pcnt_q[blk_q] + 3'h1 : 3'h1;
		end
	end

	// Helper: last command strobed, for sequence checks.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			last_cmd_q <= 8'h00;
		else if (cle && !we_n)
			last_cmd_q <= io_out;
	end

	AST_INIT_CMDS: assert property (@(posedge clk) disable iff (!rst_n)
		init_q && cle && $fell(we_n) |-> io_out inside {8'hFF, 8'h70})
		else $error("Command other than reset or status during init.");
	AST_KNOWN_CMD: assert property (@(posedge clk) disable iff (!rst_n)
		cle && $fell(we_n) |-> io_out inside {8'h00, 8'h30, 8'h80, 8'h10, 8'h60, 8'hD0,
		8'h70, 8'hFF})
		else $error("Undefined command code sent.");
	AST_BUSY_CMDS: assert property (@(posedge clk) disable iff (!rst_n)
		cle && $fell(we_n) && !rb_s2_q && !init_q |-> io_out inside {8'h70, 8'h71, 8'hFF})
		else $error("Command sent while device busy.");
	AST_AFTER_PROG1: assert property (@(posedge clk) disable iff (!rst_n)
		cle && $fell(we_n) && last_cmd_q == 8'h80 |-> io_out inside {8'h85, 8'h10, 8'h11,
		8'h15, 8'hFF})
		else $error("Illegal command after serial data input.");
	AST_ORDER: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == nfh_pkg::S_IDLE && req_valid && req_op == nfh_pkg::OP_PROG &&
		pcnt_q[req_blk] != 3'h0 && req_pg < lastp_q[req_blk] |=> refused &&
		state_q == nfh_pkg::S_IDLE)
		else $error("Out of order page program accepted.");
	AST_PARTIAL: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == nfh_pkg::S_IDLE && req_valid && req_op == nfh_pkg::OP_PROG &&
		pcnt_q[req_blk] == nfh_pkg::MAX_PARTIAL && req_pg == lastp_q[req_blk] |=>
		refused ##1 !busy)
		else $error("Fifth partial program accepted.");
	AST_NO_ERASE_BAD: assert property (@(posedge clk) disable iff (!rst_n)
		state_q == nfh_pkg::S_IDLE && req_valid && req_op == nfh_pkg::OP_ERASE &&
		bad_q[req_blk] |=> refused)
		else $error("Erase of bad block accepted.");
	AST_FAIL_MARKS: assert property (@(posedge clk) disable iff (!rst_n)
		done && done_err && $past(state_q) == nfh_pkg::S_SRD |=> bad_q[blk_q])
		else $error("Failed block not marked bad.");
	AST_READY_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
		done && $past(state_q) == nfh_pkg::S_SRD |-> rd_data[nfh_pkg::ST_READY_BIT])
		else $error("Result taken before ready bit.");
	AST_SCAN_MARK: assert property (@(posedge clk) disable iff (!rst_n)
		rd_valid && op_q == 3'h4 && rd_data == 8'h00 |-> ##[1:20] bad_q[blk_q])
		else $error("Scanned zero mark not recorded.");

	COV_PROG: cover property (@(posedge clk) disable iff (!rst_n)
		done && !done_err && op_q == 3'h1);
	COV_PROG_FAIL: cover property (@(posedge clk) disable iff (!rst_n)
		done && done_err && op_q == 3'h1);
	COV_SCAN_BAD: cover property (@(posedge clk) disable iff (!rst_n)
		done && done_err && op_q == 3'h4);
	COV_REFUSE: cover property (@(posedge clk) disable iff (!rst_n) refused);
endmodule

// ---- src/nfh_pkg.sv ----
/*
  Constants for the NAND flash host sequencer: command codes, user operation codes,
  status bit positions, array geometry and pin timing derived from the clock rate.
  Assumes a 100 MHz system clock.
*/
package nfh_pkg;
	// Command codes of the device command set; nothing else is ever sent.
	localparam logic [7:0] CMD_READ1   = 8'h00;
	localparam logic [7:0] CMD_READ2   = 8'h30;
	localparam logic [7:0] CMD_PROG1   = 8'h80;
	localparam logic [7:0] CMD_PROG2   = 8'h10;
	localparam logic [7:0] CMD_COLCHG  = 8'h85;
	localparam logic [7:0] CMD_MULTI   = 8'h11;
	localparam logic [7:0] CMD_CACHE   = 8'h15;
	localparam logic [7:0] CMD_ERASE1  = 8'h60;
	localparam logic [7:0] CMD_ERASE2  = 8'hD0;
	localparam logic [7:0] CMD_STATUS  = 8'h70;
	localparam logic [7:0] CMD_STATUS2 = 8'h71;
	localparam logic [7:0] CMD_RESET   = 8'hFF;
	// User operation codes.
	localparam logic [2:0] OP_READ  = 3'h0;
	localparam logic [2:0] OP_PROG  = 3'h1;
	localparam logic [2:0] OP_ERASE = 3'h2;
	localparam logic [2:0] OP_RESET = 3'h3;
	localparam logic [2:0] OP_SCAN  = 3'h4;
	// Status byte fields and the bad block mark.
	localparam int         ST_FAIL_BIT  = 0;
	localparam int         ST_READY_BIT = 6;
	localparam logic [7:0] BAD_MARK     = 8'h00;
	localparam logic [2:0] MAX_PARTIAL  = 3'h4;
	// Geometry.
	localparam int BLK_W  = 12;
	localparam int PG_W   = 6;
	localparam int COL_W  = 13;
	localparam int BLOCKS = 4096;
	localparam logic [2:0] ADDR_FIRST_FULL  = 3'h0;
	localparam logic [2:0] ADDR_FIRST_ROW   = 3'h2;
	localparam logic [2:0] ADDR_LAST        = 3'h4;
	// Pin timing in ns; least times round up to whole cycles.
	localparam int CLK_MHZ    = 100;
	localparam int WE_LOW_NS  = 30;
	localparam int WE_HIGH_NS = 30;
	localparam int RE_LOW_NS  = 60;
	localparam int RE_HIGH_NS = 30;
	localparam int TWB_NS     = 100;
	localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int WE_CYC     = WE_LOW_CYC + (WE_HIGH_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int RE_LOW_CYC = (RE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int RE_CYC     = RE_LOW_CYC + (RE_HIGH_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int TWB_CYC    = (TWB_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [3:0] {S_INIT, S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_TWB, S_RB,
		S_SCMD, S_SRD, S_RDATA} nfh_state_type;
endpackage
